// file: hdl/tlc_limit_regs.sv
// Result, identification and setpoint registers with limit comparison and alarm pins.
// Assumes a serial front end delivers one-cycle register requests and the converter
// delivers one-cycle 16-bit results, both synchronous to sys_clk.
//
// How it works
// - Result above critical limit flags critical event
// - Critical event drives critical alarm pin active
// - Critical limit 16-bit signed, resets 0x4980
// - Result above upper limit flags, asserts alarm
// - Result below lower limit flags, asserts alarm
// - Upper limit 16-bit signed, resets 0x2000
// - Lower limit 16-bit signed, resets 0x0500
// - Hysteresis 4-bit unsigned degrees, resets 5
// - Release thresholds offset by hysteresis value
// - 13-bit mode result bit0 flags below-lower
// - 13-bit mode result bit1 flags above-upper
// - 13-bit mode result bit2 flags above-critical
// - 16-bit mode low bits carry temperature
// - Result read-only, signed, resets to zero
// - Identification holds revision and maker codes
// - Fault queue needs 1-4 consecutive faults
// - Status flags clear on read or recovery
// - Comparator mode releases alarm past hysteresis
// - Interrupt mode releases on read, rearms freshly
`timescale 1ns/1ps
`default_nettype none
`include "tlc_defines.svh"

module tlc_limit_regs
    import tlc_pkg::*;
#(
    // Arbitrary neutral identification values
    parameter logic [4:0] MAKER_CODE = 5'h0a,
    parameter logic [2:0] REV_CODE   = 3'h1
) (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire tlc_req_t    regReq,
    input  wire tlc_conv_t   convIn,
    output logic [15:0]      regRdData_r,
    output logic             regRdValid_r,
    output logic             critical_alarm_pin_o_r,
    output logic             critical_alarm_pin_oe_r,
    output logic             limitAlarmPin_o_r,
    output logic             limitAlarmPin_oe_r
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [15:0] critical_limit_r;
    logic [15:0] upper_limit_r;
    logic [15:0] lower_limit_r;
    logic [7:0]  hysteresis_value_r;
    logic [7:0]  config_r;
    logic [15:0] temperature_result_r;
    logic        stLow_r;
    logic        stHigh_r;
    logic        stCrit_r;
    logic        rdyN_r;
    logic [2:0]  limitFaultCnt_r;
    logic [2:0]  critFaultCnt_r;
    logic        intActive_r;
    logic        ctActive_r;
    logic        limitArmed_r;
    logic        critArmed_r;

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    wire        wrCrit   = regReq.wr && (regReq.addr == `TLC_ADDR_CRIT);
    wire        wrHyst   = regReq.wr && (regReq.addr == `TLC_ADDR_HYST);
    wire        wrUpper  = regReq.wr && (regReq.addr == `TLC_ADDR_UPPER);
    wire        wrLower  = regReq.wr && (regReq.addr == `TLC_ADDR_LOWER);
    wire        wrConfig = regReq.wr && (regReq.addr == `TLC_ADDR_CONFIG);
    wire        rdStatus = regReq.rd && (regReq.addr == `TLC_ADDR_STATUS);
    wire        rdResult = regReq.rd && (regReq.addr == `TLC_ADDR_RESULT);
    wire        anyRead  = regReq.rd;

    wire        hiRes    = config_r[`TLC_CFG_RES];
    wire [1:0]  faultQ   = config_r[`TLC_CFG_FQ_HI:`TLC_CFG_FQ_LO];
    wire        cmpMode  = config_r[`TLC_CFG_CMP_MODE];
    // Shutdown entry clears the limit alarm only in interrupt mode
    wire        shutWr   = wrConfig && !regReq.wdata[`TLC_CFG_CMP_MODE]
                        && (regReq.wdata[`TLC_CFG_OP_HI:`TLC_CFG_OP_LO] == `TLC_OP_SHUTDOWN);

    ////////////////////////////////////////////////////////////////////////////
    // Comparison on the incoming result
    // flag bits dropped in 13-bit mode
    wire [15:0] tempVal  = hiRes ? convIn.temp : {convIn.temp[15:3], 3'h0};
    wire [16:0] hystOff  = {9'h000, hysteresis_value_r[3:0], 4'h0} << (`TLC_HYST_SHIFT - 4);
    // signed compares, 17 bits to avoid wrap
    wire signed [16:0] tS     = {tempVal[15], tempVal};
    wire signed [16:0] critS  = {critical_limit_r[15], critical_limit_r};
    wire signed [16:0] upperS = {upper_limit_r[15], upper_limit_r};
    wire signed [16:0] lowerS = {lower_limit_r[15], lower_limit_r};
    wire signed [16:0] critRel  = critS - $signed(hystOff);
    wire signed [16:0] upperRel = upperS - $signed(hystOff);
    wire signed [16:0] lowerRel = lowerS + $signed(hystOff);

    wire        overCrit  = tS > critS;
    wire        overHigh  = tS > upperS;
    wire        underLow  = tS < lowerS;
    wire        critBack  = tS < critRel;
    wire        limitBack = (tS < upperRel) && (tS > lowerRel);

    wire        conv      = convIn.valid;

    ////////////////////////////////////////////////////////////////////////////
    // Fault queue
    wire        limitFault = overHigh || underLow;
    wire [2:0]  limitCnt_nxt = !limitFault ? 3'h0 :
                               (limitFaultCnt_r == `TLC_FAULT_MAX) ? limitFaultCnt_r : limitFaultCnt_r + 3'h1;
    wire [2:0]  critCnt_nxt  = !overCrit ? 3'h0 :
                               (critFaultCnt_r == `TLC_FAULT_MAX) ? critFaultCnt_r : critFaultCnt_r + 3'h1;
    wire        limitQual = conv && (limitCnt_nxt > {1'b0, faultQ});
    wire        critQual  = conv && (critCnt_nxt > {1'b0, faultQ});

    ////////////////////////////////////////////////////////////////////////////
    // Alarm state
    // in interrupt mode a fresh crossing needs rearm after recovery
    wire        intSet  = limitQual && (cmpMode || limitArmed_r);
    wire        ctSet   = critQual && (cmpMode || critArmed_r);
    wire        intCmpClr = cmpMode && conv && limitBack;
    wire        ctCmpClr  = cmpMode && conv && critBack;
    // any read releases in interrupt mode
    wire        intRdClr  = !cmpMode && (anyRead || shutWr);
    wire        ctRdClr   = !cmpMode && anyRead;

    // limit alarm, set wins over clear
    wire        intActive_nxt = intSet || (intActive_r && !intCmpClr && !intRdClr);
    // critical alarm, set wins over clear
    wire        ctActive_nxt  = ctSet || (ctActive_r && !ctCmpClr && !ctRdClr);

    wire        limitArmed_nxt = intSet ? 1'b0 : ((conv && limitBack) ? 1'b1 : limitArmed_r);
    wire        critArmed_nxt  = ctSet ? 1'b0 : ((conv && critBack) ? 1'b1 : critArmed_r);

    ////////////////////////////////////////////////////////////////////////////
    // Status flags
    // clear on status read or recovery; set wins
    wire        stLow_nxt  = (conv && underLow) || (stLow_r && !rdStatus && !(conv && limitBack));
    wire        stHigh_nxt = (conv && overHigh) || (stHigh_r && !rdStatus && !(conv && limitBack));
    wire        stCrit_nxt = (conv && overCrit) || (stCrit_r && !rdStatus && !(conv && critBack));
    // Conversion wins over a simultaneous result read
    wire        rdyN_nxt   = conv ? 1'b0 : (rdResult ? 1'b1 : rdyN_r);

    ////////////////////////////////////////////////////////////////////////////
    // Result word
    wire [2:0]  flagBits;
    assign flagBits[`TLC_RES_LOW]  = underLow;
    assign flagBits[`TLC_RES_HIGH] = overHigh;
    assign flagBits[`TLC_RES_CRIT] = overCrit;
    // extra bits or flags by resolution
    wire [15:0] result_nxt = hiRes ? convIn.temp : {convIn.temp[15:3], flagBits};

    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    wire [7:0]  statusWord = {rdyN_r, stCrit_r, stHigh_r, stLow_r, 4'h0};
    wire [7:0]  identWord  = {MAKER_CODE, REV_CODE};
    // One-hot selects keep the read path a flat AND-OR with no priority chain
    wire        selStatus = (regReq.addr == `TLC_ADDR_STATUS);
    wire        selConfig = (regReq.addr == `TLC_ADDR_CONFIG);
    wire        selResult = (regReq.addr == `TLC_ADDR_RESULT);
    wire        selIdent  = (regReq.addr == `TLC_ADDR_IDENT);
    wire        selCrit   = (regReq.addr == `TLC_ADDR_CRIT);
    wire        selHyst   = (regReq.addr == `TLC_ADDR_HYST);
    wire        selUpper  = (regReq.addr == `TLC_ADDR_UPPER);
    wire        selLower  = (regReq.addr == `TLC_ADDR_LOWER);
    wire [15:0] rdMux     = ({16{selStatus}} & {8'h00, statusWord})
                          | ({16{selConfig}} & {8'h00, config_r})
                          | ({16{selResult}} & temperature_result_r)
                          | ({16{selIdent}}  & {8'h00, identWord})
                          | ({16{selCrit}}   & critical_limit_r)
                          | ({16{selHyst}}   & {8'h00, hysteresis_value_r})
                          | ({16{selUpper}}  & upper_limit_r)
                          | ({16{selLower}}  & lower_limit_r);

    // Pin drive: open drain pulls low when the level must be low
    wire ctPinOe_nxt  = ctActive_r ^ config_r[`TLC_CFG_CT_POL];
    wire intPinOe_nxt = intActive_r ^ config_r[`TLC_CFG_INT_POL];

    ////////////////////////////////////////////////////////////////////////////
    // Setpoints and configuration, one short block per register
    // critical limit register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            critical_limit_r <= `TLC_RST_CRIT;
        end else if (wrCrit) begin
            critical_limit_r <= regReq.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            upper_limit_r <= `TLC_RST_UPPER;
        end else if (wrUpper) begin
            upper_limit_r <= regReq.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lower_limit_r <= `TLC_RST_LOWER;
        end else if (wrLower) begin
            lower_limit_r <= regReq.wdata;
        end
    end

    // hysteresis register, upper nibble kept for read-back only
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hysteresis_value_r <= `TLC_RST_HYST;
        end else if (wrHyst) begin
            hysteresis_value_r <= regReq.wdata[7:0];
        end
    end

    // Configuration register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            config_r <= `TLC_RST_CONFIG;
        end else if (wrConfig) begin
            config_r <= regReq.wdata[7:0];
        end
    end

    // Result and status
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            temperature_result_r <= `TLC_RST_RESULT;
            stLow_r  <= 1'b0;
            stHigh_r <= 1'b0;
            stCrit_r <= 1'b0;
            rdyN_r   <= 1'b1;
        end else begin
            if (conv) temperature_result_r <= result_nxt;
            stLow_r  <= stLow_nxt;
            stHigh_r <= stHigh_nxt;
            stCrit_r <= stCrit_nxt;
            rdyN_r   <= rdyN_nxt;
        end
    end

    // Fault queue and alarms
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            limitFaultCnt_r <= 3'h0;
            critFaultCnt_r  <= 3'h0;
            intActive_r     <= 1'b0;
            ctActive_r      <= 1'b0;
            limitArmed_r    <= 1'b1;
            critArmed_r     <= 1'b1;
        end else begin
            if (conv) limitFaultCnt_r <= limitCnt_nxt;
            if (conv) critFaultCnt_r  <= critCnt_nxt;
            intActive_r  <= intActive_nxt;
            ctActive_r   <= ctActive_nxt;
            limitArmed_r <= limitArmed_nxt;
            critArmed_r  <= critArmed_nxt;
        end
    end

    // Read port
    // Data holds between reads so a slow front end may sample it late
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            regRdData_r  <= 16'h0000;
            regRdValid_r <= 1'b0;
        end else begin
            regRdData_r  <= regReq.rd ? rdMux : regRdData_r;
            regRdValid_r <= regReq.rd;
        end
    end

    // Alarm pins: the data side stays low, only the enable moves
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            critical_alarm_pin_o_r  <= 1'b0;
            critical_alarm_pin_oe_r <= 1'b0;
            limitAlarmPin_o_r       <= 1'b0;
            limitAlarmPin_oe_r      <= 1'b0;
        end else begin
            critical_alarm_pin_o_r  <= 1'b0;
            critical_alarm_pin_oe_r <= ctPinOe_nxt;
            limitAlarmPin_o_r       <= 1'b0;
            limitAlarmPin_oe_r      <= intPinOe_nxt;
        end
    end

endmodule : tlc_limit_regs
`default_nettype wire

// file: hdl/tlc_defines.svh
// Offsets, field positions, reset values and shift counts of the limit/result block.
// Assumes it is included by bare name from the package and the design module.
`ifndef TLC_DEFINES_SVH
`define TLC_DEFINES_SVH

`define TLC_ADDR_STATUS   3'h0
`define TLC_ADDR_CONFIG   3'h1
`define TLC_ADDR_RESULT   3'h2
`define TLC_ADDR_IDENT    3'h3
`define TLC_ADDR_CRIT     3'h4
`define TLC_ADDR_HYST     3'h5
`define TLC_ADDR_UPPER    3'h6
`define TLC_ADDR_LOWER    3'h7

`define TLC_RST_CRIT      16'h4980
`define TLC_RST_HYST      8'h05
`define TLC_RST_UPPER     16'h2000
`define TLC_RST_LOWER     16'h0500
`define TLC_RST_CONFIG    8'h00
`define TLC_RST_RESULT    16'h0000

// Configuration field positions
`define TLC_CFG_FQ_HI     1
`define TLC_CFG_FQ_LO     0
`define TLC_CFG_CT_POL    2
`define TLC_CFG_INT_POL   3
`define TLC_CFG_CMP_MODE  4
`define TLC_CFG_OP_HI     6
`define TLC_CFG_OP_LO     5
`define TLC_CFG_RES       7
`define TLC_OP_SHUTDOWN   2'h3

// Status field positions
`define TLC_ST_LOW        4
`define TLC_ST_HIGH       5
`define TLC_ST_CRIT       6
`define TLC_ST_RDYN       7

// Result flag positions in 13-bit mode
`define TLC_RES_LOW       0
`define TLC_RES_HIGH      1
`define TLC_RES_CRIT      2

// One degree is 128 LSBs of the 16-bit format
`define TLC_HYST_SHIFT    7
`define TLC_FAULT_MAX     3'h4

`endif

// file: hdl/tlc_pkg.sv
// Types shared by the limit/result block and its bench.
// Assumes tlc_defines.svh is on the include path.
package tlc_pkg;
    `include "tlc_defines.svh"

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [2:0]  addr;
        logic [15:0] wdata;
    } tlc_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] temp;
    } tlc_conv_t;
endpackage : tlc_pkg

// file: verification/tlc_host_model.sv
// Host side: issues register requests and pulls up both open-drain alarm lines.
// Assumes the bench calls acc and shares sys_clk.
`timescale 1ns/1ps
`default_nettype none
module tlc_host_model
    import tlc_pkg::*;
(
    input  wire logic        sys_clk,
    output var  tlc_req_t    regReq,
    input  wire logic [15:0] regRdData_r,
    input  wire logic        regRdValid_r,
    input  wire logic        ctOe,
    input  wire logic        intOe,
    output logic             ctPin,
    output logic             intPin
);
    // Pull-ups own the lines whenever the device lets go
    assign ctPin  = ctOe ? 1'b0 : 1'b1;
    assign intPin = intOe ? 1'b0 : 1'b1;
    initial regReq = '0;
    // Request held one cycle; answer taken after the edge that follows
    task automatic acc(input logic w, input logic [2:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge sys_clk) #1;
        regReq = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge sys_clk) #1;
        regReq = '0;
        q = regRdValid_r ? regRdData_r : 16'hxxxx;
    endtask : acc
endmodule : tlc_host_model
`default_nettype wire

// file: verification/tlc_limit_regs_props.sv
// Port checker for the limit/result block.
// Assumes setpoints change only through observed register writes on its ports.
`timescale 1ns/1ps
`default_nettype none
module tlc_limit_regs_props
    import tlc_pkg::*;
#(
    parameter logic [4:0] MAKER_CODE = 5'h0a,
    parameter logic [2:0] REV_CODE   = 3'h1
) (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire tlc_req_t    regReq,
    input wire tlc_conv_t   convIn,
    input wire logic [15:0] regRdData_r,
    input wire logic        regRdValid_r,
    input wire logic        critical_alarm_pin_o_r,
    input wire logic        critical_alarm_pin_oe_r,
    input wire logic        limitAlarmPin_o_r,
    input wire logic        limitAlarmPin_oe_r
);
    logic [15:0] crit_r, upper_r, lower_r, tM;
    logic [7:0]  cfg_r;
    logic        cmpQ;
    // Shadow setpoints so alarm causes can be judged from ports alone
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            {crit_r, upper_r, lower_r, cfg_r} <= {16'h4980, 16'h2000, 16'h0500, 8'h00};
        end else if (regReq.wr) begin
            if (regReq.addr == 3'h1) cfg_r <= regReq.wdata[7:0];
            if (regReq.addr == 3'h4) crit_r <= regReq.wdata;
            if (regReq.addr == 3'h6) upper_r <= regReq.wdata;
            if (regReq.addr == 3'h7) lower_r <= regReq.wdata;
        end
    end
    assign tM   = cfg_r[7] ? convIn.temp : {convIn.temp[15:3], 3'h0};
    assign cmpQ = convIn.valid && cfg_r[4] && cfg_r[1:0] == 2'h0;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    a_rd_answer: assert property (regReq.rd |=> regRdValid_r) else $error("read not answered");
    a_rd_quiet: assert property (!regReq.rd |=> !regRdValid_r && $stable(regRdData_r))
        else $error("read port moved without a read");
    a_id_value: assert property (regReq.rd && regReq.addr == 3'h3 |=> regRdData_r == {8'h00, MAKER_CODE, REV_CODE})
        else $error("identification wrong");
    a_drain_only: assert property (!critical_alarm_pin_o_r && !limitAlarmPin_o_r) else $error("pin driven high");
    a_crit_alarm: assert property (cmpQ && $signed(tM) > $signed(crit_r)
        |=> ##1 critical_alarm_pin_oe_r != $past(cfg_r[2])) else $error("critical alarm missing");
    a_high_alarm: assert property (cmpQ && $signed(tM) > $signed(upper_r)
        |=> ##1 limitAlarmPin_oe_r != $past(cfg_r[3])) else $error("high alarm missing");
    a_low_alarm: assert property (cmpQ && $signed(tM) < $signed(lower_r)
        |=> ##1 limitAlarmPin_oe_r != $past(cfg_r[3])) else $error("low alarm missing");
    a_irq_release: assert property (regReq.rd && !convIn.valid && !cfg_r[4]
        |=> ##1 limitAlarmPin_oe_r == $past(cfg_r[3]) && critical_alarm_pin_oe_r == $past(cfg_r[2]))
        else $error("read kept alarm");
    c_limit_rise: cover property ($rose(limitAlarmPin_oe_r));
    c_crit_rise: cover property ($rose(critical_alarm_pin_oe_r));
    c_cfg_write: cover property (regReq.wr && regReq.addr == 3'h1);
endmodule : tlc_limit_regs_props
bind tlc_limit_regs tlc_limit_regs_props #(.MAKER_CODE(MAKER_CODE), .REV_CODE(REV_CODE)) u_props (
    .sys_clk(sys_clk), .nrst(nrst), .regReq(regReq), .convIn(convIn), .regRdData_r(regRdData_r),
    .regRdValid_r(regRdValid_r), .critical_alarm_pin_o_r(critical_alarm_pin_o_r),
    .critical_alarm_pin_oe_r(critical_alarm_pin_oe_r), .limitAlarmPin_o_r(limitAlarmPin_o_r),
    .limitAlarmPin_oe_r(limitAlarmPin_oe_r));
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the limit/result block.
// Assumes the host model issues every register request.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import tlc_pkg::*;
;
    localparam logic [4:0]  MK = 5'h0a; // Arbitrary maker value
    localparam logic [2:0]  RV = 3'h1;  // Arbitrary revision value
    localparam logic [15:0] ID = {8'h00, MK, RV};
    logic        sys_clk, nrst, ctPin, intPin, ctO, ctOe, inO, inOe, rdV;
    logic [15:0] rdD;
    tlc_req_t    regReq;
    tlc_conv_t   convIn;
    int          err_total = 0, n_tests = 0, cyc = 0;
    tlc_limit_regs #(.MAKER_CODE(MK), .REV_CODE(RV)) dut (.sys_clk(sys_clk), .nrst(nrst), .regReq(regReq),
        .convIn(convIn), .regRdData_r(rdD), .regRdValid_r(rdV), .critical_alarm_pin_o_r(ctO),
        .critical_alarm_pin_oe_r(ctOe), .limitAlarmPin_o_r(inO), .limitAlarmPin_oe_r(inOe));
    tlc_host_model host (.sys_clk(sys_clk), .regReq(regReq), .regRdData_r(rdD), .regRdValid_r(rdV),
        .ctOe(ctOe), .intOe(inOe), .ctPin(ctPin), .intPin(intPin));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic pinChk(input logic ct, input logic in);
        n_tests++;
        if ({ctPin, intPin} !== {ct, in}) begin
            err_total++;
            $display("[ERR] %0t pins %b%b exp %b%b", $time, ctPin, intPin, ct, in);
        end
    endtask : pinChk
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        logic [15:0] q;
        host.acc(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        logic [15:0] q;
        host.acc(1'b0, a, 16'h0000, q);
        chk(q, e);
    endtask : rd
    // Leaves two edges after the take so the pin outputs have settled
    task automatic cv(input logic [15:0] t);
        @(posedge sys_clk) #1;
        convIn = '{valid: 1'b1, temp: t};
        @(posedge sys_clk) #1;
        convIn.valid = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : cv
    ////////////////////////////////////////////////////////////////
    task automatic t_access;
        logic [15:0] e [8] = '{16'h0080, 16'h0000, 16'h0000, ID, 16'h4980, 16'h0005, 16'h2000, 16'h0500};
        logic [15:0] v [8] = '{16'hc180, 16'h00f7, 16'h8000, 16'h7fff, 16'h4980, 16'h0005, 16'h2000, 16'h0500};
        for (int i = 0; i < 8; i++) rd(3'(i), e[i]);
        for (int i = 0; i < 8; i++) begin
            wr(3'(4 + i % 4), v[i]);
            rd(3'(4 + i % 4), v[i]);
        end
        wr(3'h2, 16'h1234);
        rd(3'h2, 16'h0000);
        wr(3'h3, 16'h00ff);
        rd(3'h3, ID);
    endtask : t_access
    task automatic t_flags;
        logic [15:0] t [6] = '{16'h2107, 16'h0400, 16'h5000, 16'hff00, 16'h2105, 16'h0402};
        logic [15:0] e [6] = '{16'h2102, 16'h0401, 16'h5006, 16'hff01, 16'h2105, 16'h0402};
        for (int i = 0; i < 6; i++) begin
            if (i == 4) wr(3'h1, 16'h0080);
            cv(t[i]);
            rd(3'h2, e[i]);
        end
        wr(3'h1, 16'h0000);
    endtask : t_flags
    task automatic t_comp;
        logic [15:0] t [8] = '{16'h2100, 16'h1e00, 16'h1d00, 16'h0400, 16'h0800, 16'h4a00, 16'h4900, 16'h1000};
        logic [7:0]  ce = 8'h9f;
        logic [7:0]  ie = 8'h94;
        wr(3'h1, 16'h0010);
        for (int i = 0; i < 8; i++) begin
            cv(t[i]);
            pinChk(ce[i], ie[i]);
        end
        wr(3'h1, 16'h0013);
        for (int i = 0; i < 4; i++) begin
            cv(16'h2100);
            pinChk(1'b1, i < 3);
        end
        cv(16'h1000);
        wr(3'h1, 16'h0000);
        cv(16'h1000);
    endtask : t_comp
    task automatic t_int;
        logic [15:0] t [4] = '{16'h0400, 16'h0400, 16'h0800, 16'h0400};
        logic [3:0]  ie = 4'h6;
        for (int i = 0; i < 4; i++) begin
            cv(t[i]);
            pinChk(1'b1, ie[i]);
            if (i == 0) begin
                rd(3'h3, ID);
                @(posedge sys_clk) #1;
                pinChk(1'b1, 1'b1);
            end
        end
        wr(3'h1, 16'h0060);
        @(posedge sys_clk) #1;
        pinChk(1'b1, 1'b1);
        rd(3'h0, 16'h0010);
        rd(3'h0, 16'h0000);
        wr(3'h1, 16'h000c);
        @(posedge sys_clk) #1;
        pinChk(1'b0, 1'b0);
    endtask : t_int
    ////////////////////////////////////////////////////////////////
    task automatic results;
        if (err_total == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            $display("[ERR] %0t timeout", $time);
            results();
        end
    end
    initial begin
        nrst = 1'b0;
        convIn = '0;
        repeat (12) @(posedge sys_clk);
        #1 nrst = 1'b1;
        t_access();
        t_flags();
        t_comp();
        t_int();
        results();
    end
endmodule : tb_top
`default_nettype wire
